// ### inc/nvirq_pkg.sv
// Contract
// R01 - 32 interrupt lines, four priority levels
// R02 - Accepted exceptions run in handler mode
// R03 - Strictly higher priority preempts running handler
// R04 - Exception number supplied on acceptance
// R05 - Vector table at zero, number times four
// R06 - Core stacks registers at entry, restores after
// R07 - Pending handler chains at return, no restore
// R08 - Late higher request redirects entry, no penalty
// R09 - Level 0 most urgent; reset to 0
// R10 - Reset, NMI, hard fault fixed above all
// R11 - Fixed exception numbers; irq at 16..47
// R12 - Low interrupt bit assignment, 2 and 9 reserved
// R13 - High interrupt bit assignment, gaps reserved
// R14 - Write-one enable and disable; both read state
// R15 - Disabled interrupt pends but never activates
// R16 - Disabling an active interrupt keeps it active
// R17 - Write-one set and clear pending; both read
// R18 - Clearing pending leaves active status alone
// R19 - Priority in byte lanes, four per word
// R20 - Register offsets 0x100..0x280, priorities from 0x400
// R21 - Equal levels: lowest exception number wins
package nvirq_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFS_SET_EN = 12'h100; // R20
  localparam logic [11:0] OFS_CLR_EN = 12'h180;
  localparam logic [11:0] OFS_SET_PEND = 12'h200;
  localparam logic [11:0] OFS_CLR_PEND = 12'h280;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h400;
  localparam logic [11:0] OFS_PRIO_LAST = 12'h41C;
  localparam logic [11:0] OFS_CTRL_STAT = 12'hD04;
  localparam logic [11:0] OFS_SYS_PRI2 = 12'hD1C;
  localparam logic [11:0] OFS_SYS_PRI3 = 12'hD20;

  // ==========================================================
  // Reset values and field positions
  localparam logic [31:0] EN_RST = 32'h0000_0000;
  localparam logic [31:0] PEND_RST = 32'h0000_0000;
  localparam logic [1:0] PRIO_RST = 2'h0;
  localparam logic [47:0] ACTIVE_RST = 48'h0000_0000_0000;
  localparam int PRIO_LANE_LSB = 6;
  localparam int CS_NMI_SET = 31;
  localparam int CS_PSV_SET = 28;
  localparam int CS_PSV_CLR = 27;
  localparam int CS_TCK_SET = 26;
  localparam int CS_TCK_CLR = 25;
  localparam int CS_REQ = 22;
  localparam int CS_WIN_LSB = 12;
  localparam int SP2_SVC_LSB = 30;
  localparam int SP3_PSV_LSB = 22;
  localparam int SP3_TCK_LSB = 30;

  // ==========================================================
  // Exception numbers and urgency levels (lower level wins)
  localparam logic [5:0] EXC_RESET = 6'h01;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD_FAULT = 6'h03;
  localparam logic [5:0] EXC_SUPERVISOR_CALL = 6'h0B;
  localparam logic [5:0] EXC_PENDABLE_SERVICE = 6'h0E;
  localparam logic [5:0] EXC_SYSTEM_TICK = 6'h0F;
  localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
  localparam int EXC_COUNT = 48;
  localparam logic [2:0] LVL_RESET = 3'h0;
  localparam logic [2:0] LVL_NMI = 3'h1;
  localparam logic [2:0] LVL_HARD_FAULT = 3'h2;
  localparam logic [2:0] LVL_CFG_BASE = 3'h3;
  localparam logic [2:0] LVL_THREAD = 3'h7;

  // ==========================================================
  // Vector table
  localparam logic [31:0] VEC_TABLE_BASE = 32'h0000_0000;
  localparam int VEC_STRIDE_SHIFT = 2;

  // ==========================================================
  // Interrupt line positions
  localparam int IRQ_I2C0 = 0;
  localparam int IRQ_SPI0 = 1;
  localparam int IRQ_UART0 = 3;
  localparam int IRQ_PWM_UNIT = 4;
  localparam int IRQ_CONVERTER = 5;
  localparam int IRQ_WATCHDOG = 6;
  localparam int IRQ_WINDOWED_WATCHDOG = 7;
  localparam int IRQ_TIMER_ZERO = 8;
  localparam int IRQ_SPI1 = 10;
  localparam int IRQ_RADIO_LINK_LAYER = 11;
  localparam int IRQ_UART1 = 12;
  localparam int IRQ_TIMER_ONE = 13;
  localparam int IRQ_TIMER_TWO = 14;
  localparam int IRQ_PORT0_PIN = 15;
  localparam int IRQ_PORT1_PIN = 16;
  localparam int IRQ_PORT2_PIN = 17;
  localparam int IRQ_PORT3_PIN = 18;
  localparam int IRQ_USB_DMA = 21;
  localparam int IRQ_USB = 22;
  localparam int IRQ_CLOCK_TRIM = 23;
  localparam int IRQ_DMA = 27;
  localparam int IRQ_BROWNOUT = 28;
  localparam int IRQ_SLEEP_TIMER = 29;
  localparam int IRQ_LOW_POWER = 30;
  // Reserved lines 2, 9, 19, 20, 24..26, 31 hold no enable or pending state
  localparam logic [31:0] IRQ_IMPL_MASK = 32'h78E7_FDFB;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } nvirq_bus_s;

  typedef struct packed {
    logic req;
    logic [5:0] num;
    logic [31:0] vec_addr;
    logic preempt;
    logic tail_chain;
    logic handler_mode;
  } nvirq_core_s;

endpackage : nvirq_pkg

// ### design/nvirq_ctrl.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module nvirq_ctrl #(
  parameter int NUM_IRQ = 32
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Register port
  input wire nvirq_pkg::nvirq_bus_s i_bus,
  output logic [31:0] o_rdata,
  // Interrupt sources
  input wire logic [NUM_IRQ-1:0] i_irq,
  input wire logic i_nmi_req,
  input wire logic i_hard_fault_req,
  input wire logic i_supervisor_call_req,
  input wire logic i_system_tick_req,
  // Core exception handshake
  input wire logic i_entry_ack,
  input wire logic i_exc_return,
  output nvirq_pkg::nvirq_core_s o_core
);

  // ==========================================================
  // State
  logic [NUM_IRQ-1:0] irq_en;
  logic [NUM_IRQ-1:0] irq_pend;
  logic [1:0] irq_prio [NUM_IRQ];
  logic [1:0] svc_prio;
  logic [1:0] psv_prio;
  logic [1:0] tck_prio;
  logic nmi_pend;
  logic hf_pend;
  logic svc_pend;
  logic psv_pend;
  logic tck_pend;
  logic [nvirq_pkg::EXC_COUNT-1:0] active;

  // ==========================================================
  // Decode
  logic wr_set_en;
  logic wr_clr_en;
  logic wr_set_pend;
  logic wr_clr_pend;
  logic wr_prio;
  logic wr_cs;
  logic [2:0] prio_word;
  logic accept;

  assign wr_set_en = i_bus.wr && (i_bus.addr == nvirq_pkg::OFS_SET_EN); // R20
  assign wr_clr_en = i_bus.wr && (i_bus.addr == nvirq_pkg::OFS_CLR_EN);
  assign wr_set_pend = i_bus.wr && (i_bus.addr == nvirq_pkg::OFS_SET_PEND);
  assign wr_clr_pend = i_bus.wr && (i_bus.addr == nvirq_pkg::OFS_CLR_PEND);
  assign wr_prio = i_bus.wr && (i_bus.addr >= nvirq_pkg::OFS_PRIO_BASE)
                   && (i_bus.addr <= nvirq_pkg::OFS_PRIO_LAST) && (i_bus.addr[1:0] == 2'h0);
  assign wr_cs = i_bus.wr && (i_bus.addr == nvirq_pkg::OFS_CTRL_STAT);
  assign prio_word = i_bus.addr[4:2];
  assign accept = i_entry_ack && o_core.req;

  // Urgency of a configurable level
  function automatic logic [2:0] cfg_level(input logic [1:0] prio);
    cfg_level = nvirq_pkg::LVL_CFG_BASE + {1'b0, prio}; // R09 R10
  endfunction : cfg_level

  // ==========================================================
  // Per exception pending, eligibility and level
  logic [nvirq_pkg::EXC_COUNT-1:0] pend_vec;
  logic [nvirq_pkg::EXC_COUNT-1:0] elig;
  logic [2:0] lvl [nvirq_pkg::EXC_COUNT];

  always_comb begin
    pend_vec = '0;
    pend_vec[nvirq_pkg::EXC_NMI] = nmi_pend;
    pend_vec[nvirq_pkg::EXC_HARD_FAULT] = hf_pend;
    pend_vec[nvirq_pkg::EXC_SUPERVISOR_CALL] = svc_pend;
    pend_vec[nvirq_pkg::EXC_PENDABLE_SERVICE] = psv_pend;
    pend_vec[nvirq_pkg::EXC_SYSTEM_TICK] = tck_pend;
    for (int i = 0; i < nvirq_pkg::EXC_COUNT; i++) begin
      lvl[i] = nvirq_pkg::LVL_THREAD;
    end
    lvl[nvirq_pkg::EXC_RESET] = nvirq_pkg::LVL_RESET; // R10
    lvl[nvirq_pkg::EXC_NMI] = nvirq_pkg::LVL_NMI;
    lvl[nvirq_pkg::EXC_HARD_FAULT] = nvirq_pkg::LVL_HARD_FAULT;
    lvl[nvirq_pkg::EXC_SUPERVISOR_CALL] = cfg_level(svc_prio);
    lvl[nvirq_pkg::EXC_PENDABLE_SERVICE] = cfg_level(psv_prio);
    lvl[nvirq_pkg::EXC_SYSTEM_TICK] = cfg_level(tck_prio);
    for (int i = 0; i < NUM_IRQ; i++) begin
      // Disabled lines stay pending but cannot compete
      pend_vec[16 + i] = irq_pend[i] && irq_en[i]; // R15 R11
      lvl[16 + i] = cfg_level(irq_prio[i]);
    end
    elig = pend_vec & ~active;
  end

  // ==========================================================
  // Arbitration
  logic [5:0] best_num;
  logic [2:0] best_lvl;
  logic [5:0] run_num;
  logic [2:0] run_lvl;
  logic [2:0] run2_lvl;
  logic want;

  always_comb begin
    best_num = '0;
    best_lvl = nvirq_pkg::LVL_THREAD;
    run_num = '0;
    run_lvl = nvirq_pkg::LVL_THREAD;
    run2_lvl = nvirq_pkg::LVL_THREAD;
    // Strict compare keeps the lowest number on a tie
    for (int i = 1; i < nvirq_pkg::EXC_COUNT; i++) begin
      if (elig[i] && (lvl[i] < best_lvl)) begin // R21
        best_lvl = lvl[i];
        best_num = 6'(i);
      end
      if (active[i] && (lvl[i] < run_lvl)) begin
        run_lvl = lvl[i];
        run_num = 6'(i);
      end
    end
    // Level the core falls back to once the running handler returns
    for (int i = 1; i < nvirq_pkg::EXC_COUNT; i++) begin
      if (active[i] && (6'(i) != run_num) && (lvl[i] < run2_lvl)) begin
        run2_lvl = lvl[i];
      end
    end
  end

  assign want = best_lvl < run_lvl; // R03

  // ==========================================================
  // Enables
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_en <= nvirq_pkg::EN_RST;
    end else if (wr_set_en) begin
      irq_en <= (irq_en | i_bus.wdata[NUM_IRQ-1:0]) & nvirq_pkg::IRQ_IMPL_MASK; // R14 R12 R13
    end else if (wr_clr_en) begin
      irq_en <= irq_en & ~i_bus.wdata[NUM_IRQ-1:0]; // R14 R16
    end
  end

  // ==========================================================
  // Interrupt pending
  logic [NUM_IRQ-1:0] pend_set;
  logic [NUM_IRQ-1:0] pend_clr;
  logic [NUM_IRQ-1:0] pend_take;

  always_comb begin
    pend_set = i_irq & ~active[16 +: NUM_IRQ]; // R15
    if (wr_set_pend) begin
      pend_set = pend_set | i_bus.wdata[NUM_IRQ-1:0]; // R17
    end
    pend_clr = wr_clr_pend ? i_bus.wdata[NUM_IRQ-1:0] : '0; // R17 R18
    pend_take = '0;
    if (accept && (o_core.num >= nvirq_pkg::EXC_IRQ_BASE)) begin
      pend_take[5'(o_core.num - nvirq_pkg::EXC_IRQ_BASE)] = 1'b1;
    end
  end

  // Hardware set beats a software clear; taking the exception beats both
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_pend <= nvirq_pkg::PEND_RST;
    end else begin
      irq_pend <= ((irq_pend & ~pend_clr) | pend_set) & ~pend_take & nvirq_pkg::IRQ_IMPL_MASK;
    end
  end

  // ==========================================================
  // System exception pending
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nmi_pend <= 1'b0;
      hf_pend <= 1'b0;
      svc_pend <= 1'b0;
      psv_pend <= 1'b0;
      tck_pend <= 1'b0;
    end else begin
      nmi_pend <= (nmi_pend || i_nmi_req || (wr_cs && i_bus.wdata[nvirq_pkg::CS_NMI_SET]))
                  && !(accept && o_core.num == nvirq_pkg::EXC_NMI);
      hf_pend <= (hf_pend || i_hard_fault_req)
                 && !(accept && o_core.num == nvirq_pkg::EXC_HARD_FAULT);
      svc_pend <= (svc_pend || i_supervisor_call_req)
                  && !(accept && o_core.num == nvirq_pkg::EXC_SUPERVISOR_CALL);
      psv_pend <= ((psv_pend && !(wr_cs && i_bus.wdata[nvirq_pkg::CS_PSV_CLR]))
                   || (wr_cs && i_bus.wdata[nvirq_pkg::CS_PSV_SET]))
                  && !(accept && o_core.num == nvirq_pkg::EXC_PENDABLE_SERVICE);
      tck_pend <= ((tck_pend && !(wr_cs && i_bus.wdata[nvirq_pkg::CS_TCK_CLR]))
                   || i_system_tick_req || (wr_cs && i_bus.wdata[nvirq_pkg::CS_TCK_SET]))
                  && !(accept && o_core.num == nvirq_pkg::EXC_SYSTEM_TICK);
    end
  end

  // ==========================================================
  // Priorities
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        irq_prio[i] <= nvirq_pkg::PRIO_RST; // R09
      end
    end else if (wr_prio) begin
      for (int b = 0; b < 4; b++) begin
        // Only the top two bits of each byte lane are kept
        irq_prio[{prio_word, 2'(b)}] <= i_bus.wdata[8*b+nvirq_pkg::PRIO_LANE_LSB +: 2]; // R19 R01
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      svc_prio <= nvirq_pkg::PRIO_RST;
      psv_prio <= nvirq_pkg::PRIO_RST;
      tck_prio <= nvirq_pkg::PRIO_RST;
    end else if (i_bus.wr && i_bus.addr == nvirq_pkg::OFS_SYS_PRI2) begin
      svc_prio <= i_bus.wdata[nvirq_pkg::SP2_SVC_LSB +: 2];
    end else if (i_bus.wr && i_bus.addr == nvirq_pkg::OFS_SYS_PRI3) begin
      psv_prio <= i_bus.wdata[nvirq_pkg::SP3_PSV_LSB +: 2];
      tck_prio <= i_bus.wdata[nvirq_pkg::SP3_TCK_LSB +: 2];
    end
  end

  // ==========================================================
  // Active set; core stacks on entry and unstacks on return
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active <= nvirq_pkg::ACTIVE_RST;
    end else begin
      for (int i = 0; i < nvirq_pkg::EXC_COUNT; i++) begin
        if (accept && o_core.num == 6'(i)) begin
          active[i] <= 1'b1; // R02 R06
        end else if (i_exc_return && run_num == 6'(i)) begin
          active[i] <= 1'b0; // R16 R06
        end
      end
    end
  end

  // ==========================================================
  // Core outputs
  // Number tracks the best candidate until acknowledge
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_core <= '0;
    end else begin
      o_core.req <= want; // R03 R08
      o_core.num <= best_num; // R04 R11
      o_core.vec_addr <= nvirq_pkg::VEC_TABLE_BASE
                         | {24'h00_0000, best_num, 2'h0}; // R05
      o_core.preempt <= want && (|active); // R03
      o_core.tail_chain <= i_exc_return && (best_lvl < run2_lvl); // R07
      o_core.handler_mode <= |active; // R02
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_bus.rd) begin
      o_rdata <= '0;
      if (i_bus.addr == nvirq_pkg::OFS_SET_EN || i_bus.addr == nvirq_pkg::OFS_CLR_EN) begin
        o_rdata <= 32'(irq_en); // R14
      end else if (i_bus.addr == nvirq_pkg::OFS_SET_PEND
                   || i_bus.addr == nvirq_pkg::OFS_CLR_PEND) begin
        o_rdata <= 32'(irq_pend); // R17
      end else if (wr_prio || (i_bus.addr >= nvirq_pkg::OFS_PRIO_BASE
                   && i_bus.addr <= nvirq_pkg::OFS_PRIO_LAST && i_bus.addr[1:0] == 2'h0)) begin
        for (int b = 0; b < 4; b++) begin
          o_rdata[8*b+nvirq_pkg::PRIO_LANE_LSB +: 2] <= irq_prio[{prio_word, 2'(b)}]; // R19
        end
      end else if (i_bus.addr == nvirq_pkg::OFS_CTRL_STAT) begin
        o_rdata[5:0] <= run_num;
        o_rdata[nvirq_pkg::CS_WIN_LSB +: 6] <= best_num;
        o_rdata[nvirq_pkg::CS_REQ] <= want;
        o_rdata[nvirq_pkg::CS_NMI_SET] <= nmi_pend;
        o_rdata[nvirq_pkg::CS_PSV_SET] <= psv_pend;
        o_rdata[nvirq_pkg::CS_TCK_SET] <= tck_pend;
      end else if (i_bus.addr == nvirq_pkg::OFS_SYS_PRI2) begin
        o_rdata[nvirq_pkg::SP2_SVC_LSB +: 2] <= svc_prio;
      end else if (i_bus.addr == nvirq_pkg::OFS_SYS_PRI3) begin
        o_rdata[nvirq_pkg::SP3_PSV_LSB +: 2] <= psv_prio;
        o_rdata[nvirq_pkg::SP3_TCK_LSB +: 2] <= tck_prio;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_irq0_disabled;
    !irq_en[0] [*2];
  endsequence

  sequence s_accept_taken;
    accept ##1 active[$past(o_core.num)];
  endsequence

  chk_set_enable: assert property ( // R14
    wr_set_en && i_bus.wdata[0] |=> irq_en[0])
    else $error("set-enable write did not enable line 0");

  chk_clear_enable: assert property ( // R14
    wr_clr_en && i_bus.wdata[3] |=> !irq_en[3])
    else $error("clear-enable write did not disable line 3");

  chk_disabled_no_entry: assert property ( // R15
    s_irq0_disabled |-> !(o_core.req && o_core.num == 6'h10))
    else $error("disabled line 0 was offered to the core");

  chk_accept_active: assert property ( // R02
    accept |-> s_accept_taken)
    else $error("accepted exception not marked active");

  chk_preempt_higher: assert property ( // R03
    o_core.req |-> $past(lvl[best_num]) < $past(run_lvl))
    else $error("request without strictly higher priority");

  chk_vector_addr: assert property ( // R05
    o_core.vec_addr == nvirq_pkg::VEC_TABLE_BASE
                       + (32'(o_core.num) << nvirq_pkg::VEC_STRIDE_SHIFT))
    else $error("vector address is not number times four");

  chk_clrpend_active: assert property ( // R18
    wr_clr_pend && !i_entry_ack && !i_exc_return |=> active == $past(active))
    else $error("clear-pending altered active state");

  chk_disable_active: assert property ( // R16
    wr_clr_en && !i_exc_return |=> (active & $past(active)) == $past(active))
    else $error("disable dropped an active exception");

  chk_set_pending: assert property ( // R17
    wr_set_pend && i_bus.wdata[0] && !accept |=> irq_pend[0])
    else $error("set-pending write did not pend line 0");

endmodule : nvirq_ctrl

// ### dv/nvirq_core_model.sv
`timescale 1ns/100ps
module nvirq_core_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Controller side
  input wire nvirq_pkg::nvirq_core_s i_core,
  output logic o_entry_ack,
  output logic o_exc_return,
  // Bench control
  input wire logic [3:0] i_ack_delay,
  input wire logic i_ret_req,
  output logic [5:0] o_taken,
  output logic [3:0] o_depth,
  output logic [7:0] o_takes
);
  logic [3:0] wait_cnt;

  // ==========================================================
  // Stacking and vector fetch time before the entry ack
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt <= 4'h0;
      o_entry_ack <= 1'b0;
    end else if (o_entry_ack || !i_core.req) begin
      wait_cnt <= 4'h0;
      o_entry_ack <= 1'b0;
    end else if (wait_cnt == i_ack_delay) begin
      o_entry_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Number taken at the ack edge, handler nesting
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_taken <= 6'h00;
      o_depth <= 4'h0;
      o_takes <= 8'h00;
      o_exc_return <= 1'b0;
    end else begin
      o_exc_return <= i_ret_req && (o_depth != 4'h0);
      if (o_entry_ack && i_core.req) begin
        o_taken <= i_core.num;
        o_takes <= o_takes + 8'h01;
      end
      // Entry and return may share an edge on a tail chain
      o_depth <= o_depth + 4'(o_entry_ack && i_core.req) - 4'(o_exc_return);
    end
  end
endmodule : nvirq_core_model

// ### dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic i_sys_clk;
  logic i_rst_b;
  nvirq_pkg::nvirq_bus_s bus;
  nvirq_pkg::nvirq_core_s core;
  logic [31:0] rdata;
  logic [31:0] irq;
  logic [3:0] sysreq;
  logic ack, ret, ret_req, tc_seen, pre_seen;
  logic [3:0] ack_dly;
  logic [3:0] depth;
  logic [5:0] taken;
  logic [7:0] takes;
  logic [31:0] v;
  int num_errors, comparisons;
  logic [11:0] ofs [7] = '{12'h100, 12'h180, 12'h200, 12'h280, 12'h400, 12'h41C, 12'h000};

  nvirq_ctrl #(.NUM_IRQ(32)) i_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_bus(bus),
    .o_rdata(rdata), .i_irq(irq), .i_nmi_req(sysreq[3]), .i_hard_fault_req(sysreq[2]),
    .i_supervisor_call_req(sysreq[1]), .i_system_tick_req(sysreq[0]),
    .i_entry_ack(ack), .i_exc_return(ret), .o_core(core));

  nvirq_core_model i_core (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_core(core),
    .o_entry_ack(ack), .o_exc_return(ret), .i_ack_delay(ack_dly), .i_ret_req(ret_req),
    .o_taken(taken), .o_depth(depth), .o_takes(takes));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Sticky flags for one-cycle pulses
  always @(posedge i_sys_clk) begin
    if (core.tail_chain === 1'b1) tc_seen <= 1'b1;
    if (core.preempt === 1'b1) pre_seen <= 1'b1;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic sys_pulse(input logic [3:0] m);
    @(posedge i_sys_clk) sysreq <= m;
    @(posedge i_sys_clk) sysreq <= 4'h0;
  endtask : sys_pulse

  task automatic do_ret();
    @(posedge i_sys_clk) ret_req <= 1'b1;
    @(posedge i_sys_clk) ret_req <= 1'b0;
  endtask : do_ret

  // Waits for the core model to take a new exception
  task automatic wait_take(input logic [5:0] n);
    logic [7:0] t0;
    int k;
    t0 = takes;
    k = 0;
    while (takes === t0 && k < 60) begin
      @(posedge i_sys_clk);
      k++;
    end
    if (k == 60) num_errors++;
    #1;
    chk({26'h0, taken}, {26'h0, n});
  endtask : wait_take

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #300000;
    num_errors++;
    give_verdict();
  end

  // ==========================================================
  // Tests
  initial begin
    i_rst_b = 1'b0;
    bus = '0;
    irq = 32'h0;
    sysreq = 4'h0;
    ret_req = 1'b0;
    ack_dly = 4'h2;
    tc_seen = 1'b0;
    pre_seen = 1'b0;
    num_errors = 0;
    comparisons = 0;
    cyc(8);
    i_rst_b <= 1'b1;
    chk({31'h0, core.req}, 32'h0);
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    $display("Test reset done");
    wr(12'h100, 32'hFFFF_FFFF);
    rdc(12'h180, nvirq_pkg::IRQ_IMPL_MASK);
    wr(12'h180, 32'h0);
    rdc(12'h100, nvirq_pkg::IRQ_IMPL_MASK);
    wr(12'h180, 32'hFFFF_FFFF);
    rdc(12'h100, 32'h0);
    $display("Test enable done");
    @(posedge i_sys_clk) irq[3] <= 1'b1;
    cyc(4);
    rdc(12'h200, 32'h8);
    chk({31'h0, core.req}, 32'h0);
    @(posedge i_sys_clk) irq[3] <= 1'b0;
    wr(12'h280, 32'h8);
    rdc(12'h200, 32'h0);
    wr(12'h200, 32'h20);
    rdc(12'h280, 32'h20);
    wr(12'h280, 32'h20);
    wr(12'h404, 32'hFFFF_FFFF);
    rdc(12'h404, 32'hC0C0_C0C0);
    rdc(12'h408, 32'h0);
    $display("Test pending done");
    wr(12'h100, 32'hFFFF_FFFF);
    @(posedge i_sys_clk) irq[4] <= 1'b1;
    cyc(3);
    #1;
    chk({26'h0, core.num}, 32'd20);
    chk(core.vec_addr, 32'h50);
    wait_take(6'd20);
    cyc(2);
    chk({31'h0, core.handler_mode}, 32'h1);
    wr(12'h280, 32'h10);
    rd(12'hD04, v);
    chk(v & 32'h3F, 32'd20);
    wr(12'h180, 32'h10);
    rd(12'hD04, v);
    chk(v & 32'h3F, 32'd20);
    wr(12'h100, 32'h10);
    $display("Test entry done");
    @(posedge i_sys_clk) irq[5] <= 1'b1;
    cyc(5);
    chk({31'h0, core.req}, 32'h0);
    @(posedge i_sys_clk) irq[3] <= 1'b1;
    wait_take(6'd19);
    chk({31'h0, pre_seen}, 32'h1);
    $display("Test preempt done");
    @(posedge i_sys_clk) irq[4:3] <= 2'b00;
    do_ret();
    cyc(3);
    chk({31'h0, tc_seen}, 32'h0);
    do_ret();
    cyc(3);
    chk({31'h0, tc_seen}, 32'h1);
    wait_take(6'd21);
    @(posedge i_sys_clk) irq[5] <= 1'b0;
    do_ret();
    cyc(3);
    chk({31'h0, core.handler_mode}, 32'h0);
    $display("Test tail chain done");
    @(posedge i_sys_clk) ack_dly <= 4'h8;
    @(posedge i_sys_clk) irq[6:5] <= 2'b11;
    cyc(3);
    sys_pulse(4'h8);
    wait_take(6'd2);
    @(posedge i_sys_clk) ack_dly <= 4'h2;
    do_ret();
    wait_take(6'd21);
    @(posedge i_sys_clk) irq[5] <= 1'b0;
    do_ret();
    wait_take(6'd22);
    @(posedge i_sys_clk) irq[6] <= 1'b0;
    do_ret();
    $display("Test late arrival done");
    sys_pulse(4'h3);
    wait_take(6'd11);
    sys_pulse(4'h4);
    wait_take(6'd3);
    do_ret();
    do_ret();
    wait_take(6'd15);
    do_ret();
    cyc(3);
    chk({31'h0, core.handler_mode}, 32'h0);
    wr(12'hD20, 32'h00C0_0000);
    rdc(12'hD20, 32'h00C0_0000);
    wr(12'hD04, 32'h1000_0000);
    wait_take(6'd14);
    do_ret();
    cyc(3);
    chk({31'h0, core.handler_mode}, 32'h0);
    $display("Test system exceptions done");
    give_verdict();
  end
endmodule : tb
